// file: verilog/ocp_phy_init_regs.sv
// maintenance command register and port-2 phy/switch init register bank
`timescale 1ns/1ps
`default_nettype none
module ocp_phy_init_regs
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // internal management register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    output logic [7:0] regRdData,
    // strap pins, asynchronous to mclk
    input wire logic port2RateStrap,
    input wire logic port2DuplexStrap,
    input wire logic port2AutonegStrap,
    // converter mode and model info from neighbouring registers
    input wire logic centerSide,
    input wire logic [23:0] modelInfoLocal,
    input wire logic [23:0] modelInfoRemote,
    // port 2 configuration
    output logic port2RateSelect,
    output logic port2DuplexSelect,
    output logic port2AutonegEnable,
    output logic remoteCmdEnable,
    output logic fabricSoftReset,
    // frame requests
    output logic sendCondInform,
    output logic sendLoopStart,
    output logic sendLoopStop,
    output logic sendRemoteCmd,
    output logic sendIndicate,
    output logic [23:0] modelInfoUpperBits
);
    logic [2:0] strapMeta_q;
    logic [2:0] strapSync_q;
    ocp_pkg::ocp_strap_t strap_q;
    ocp_pkg::ocp_strap_t strap_d;
    logic [4:0] cmd_q;
    logic rate_q;
    logic duplex_q;
    logic autoneg_q;
    logic remoteEn_q;
    logic softReset_q;
    logic wrCmd;
    logic wrInit;
    logic wrPortCtrl;
    logic [7:0] rd_d;

    ocp_cmd_if cmdBus();

    // address decode of the write strobe
    // host command write
    assign wrCmd = regWrite & (regAddr == ocp_pkg::REG_CMD);
    assign wrInit = regWrite & (regAddr == ocp_pkg::REG_PHY_SW_INIT);
    assign wrPortCtrl = regWrite & (regAddr == ocp_pkg::REG_PORT_CTRL);

    // strap pins pass two flops; the first is read only by the second
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            strapMeta_q <= 3'h0;
            strapSync_q <= 3'h0;
        end
        else
        begin
            strapMeta_q <= {port2RateStrap, port2DuplexStrap, port2AutonegStrap};
            strapSync_q <= strapMeta_q;
        end
    end

    // straps cannot be loaded under asynchronous reset, so they are caught once after release
    always_comb
    begin
        unique case (strap_q)
            ocp_pkg::STRAP_SYNC0: strap_d = ocp_pkg::STRAP_SYNC1;
            ocp_pkg::STRAP_SYNC1: strap_d = ocp_pkg::STRAP_LOAD;
            ocp_pkg::STRAP_LOAD: strap_d = ocp_pkg::STRAP_DONE;
            ocp_pkg::STRAP_DONE: strap_d = ocp_pkg::STRAP_DONE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            strap_q <= ocp_pkg::STRAP_SYNC0;
        else
            strap_q <= strap_d;
    end

    // shared speed/duplex/autoneg storage; a write through either address lands here
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rate_q <= 1'b0;
            duplex_q <= 1'b0;
            autoneg_q <= 1'b0;
        end
        else if (wrPortCtrl)
        begin
            rate_q <= regWrData[ocp_pkg::PC_RATE_BIT];
            duplex_q <= regWrData[ocp_pkg::PC_DUPLEX_BIT];
            autoneg_q <= regWrData[ocp_pkg::PC_AUTONEG_BIT];
        end
        else if (wrInit)
        begin
            rate_q <= regWrData[ocp_pkg::INIT_RATE_BIT];
            duplex_q <= regWrData[ocp_pkg::INIT_DUPLEX_BIT];
            autoneg_q <= regWrData[ocp_pkg::INIT_AUTONEG_BIT];
        end
        else if (strap_q == ocp_pkg::STRAP_LOAD)
        begin
            rate_q <= strapSync_q[2];
            duplex_q <= strapSync_q[1];
            autoneg_q <= strapSync_q[0];
        end
    end

    // remote command enable
    // enable bit storage
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            remoteEn_q <= ocp_pkg::REMOTE_EN_RESET;
        else if (wrInit)
            remoteEn_q <= regWrData[ocp_pkg::INIT_REMOTE_EN_BIT];
    end

    // one-cycle soft reset pulse; never reads back as one
    // self clearing reset
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            softReset_q <= 1'b0;
        else
            softReset_q <= wrInit & regWrData[ocp_pkg::INIT_SOFT_RESET_BIT];
    end

    // command field; soft reset returns it to CMD_RESET, while the model info source keeps its last selection
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            cmd_q <= ocp_pkg::CMD_RESET;
        else if (softReset_q)
            cmd_q <= ocp_pkg::CMD_RESET;
        else if (wrCmd & cmdBus.cmdLegal)
            cmd_q <= regWrData[ocp_pkg::CMD_WIDTH-1:0];
    end

    // hand the written code to the issuer in the write cycle
    assign cmdBus.cmdWrite = wrCmd & cmdBus.cmdLegal;
    assign cmdBus.cmdCode = regWrData[ocp_pkg::CMD_WIDTH-1:0];
    assign cmdBus.centerSide = centerSide;
    assign cmdBus.remoteEnable = remoteEn_q;
    assign cmdBus.softReset = softReset_q;

    ocp_cmd_issue issuer
    (
        .mclk(mclk),
        .nrst(nrst),
        .cmd(cmdBus),
        .modelInfoLocal(modelInfoLocal),
        .modelInfoRemote(modelInfoRemote),
        .sendCondInform(sendCondInform),
        .sendLoopStart(sendLoopStart),
        .sendLoopStop(sendLoopStop),
        .sendRemoteCmd(sendRemoteCmd),
        .sendIndicate(sendIndicate),
        .modelInfoUpperBits(modelInfoUpperBits)
    );

    // read mux; unmapped addresses and uncovered bits read zero
    always_comb
    begin
        rd_d = 8'h00;
        if (regAddr == ocp_pkg::REG_CMD)
            rd_d[ocp_pkg::CMD_WIDTH-1:0] = cmd_q;
        else if (regAddr == ocp_pkg::REG_PHY_SW_INIT)
        begin
            rd_d[ocp_pkg::INIT_RATE_BIT] = rate_q;
            rd_d[ocp_pkg::INIT_DUPLEX_BIT] = duplex_q;
            rd_d[ocp_pkg::INIT_AUTONEG_BIT] = autoneg_q;
            rd_d[ocp_pkg::INIT_REMOTE_EN_BIT] = remoteEn_q;
        end
        else if (regAddr == ocp_pkg::REG_PORT_CTRL)
        begin
            rd_d[ocp_pkg::PC_RATE_BIT] = rate_q;
            rd_d[ocp_pkg::PC_DUPLEX_BIT] = duplex_q;
            rd_d[ocp_pkg::PC_AUTONEG_BIT] = autoneg_q;
        end
    end

    // read data is registered: one cycle after the address
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            regRdData <= ocp_pkg::RD_RESET;
        else
            regRdData <= rd_d;
    end

    assign port2RateSelect = rate_q;
    assign port2DuplexSelect = duplex_q;
    assign port2AutonegEnable = autoneg_q;
    assign remoteCmdEnable = remoteEn_q;
    assign fabricSoftReset = softReset_q;
endmodule // ocp_phy_init_regs
`default_nettype wire

// file: verilog/ocp_pkg.sv
// constants and types shared by the maintenance command and port-2 init register logic
`default_nettype none
package ocp_pkg;
    // register addresses on the internal management port
    localparam logic [7:0] REG_PORT_CTRL = 8'h2C;
    localparam logic [7:0] REG_CMD = 8'h42;
    localparam logic [7:0] REG_PHY_SW_INIT = 8'h43;

    // maintenance command codes
    localparam logic [4:0] CMD_NONE = 5'h00;
    localparam logic [4:0] CMD_COND_INFORM = 5'h01;
    localparam logic [4:0] CMD_LOOP_START = 5'h02;
    localparam logic [4:0] CMD_LOOP_STOP = 5'h04;
    localparam logic [4:0] CMD_REMOTE = 5'h08;
    localparam logic [4:0] CMD_INDICATE = 5'h10;
    localparam int CMD_WIDTH = 5;

    // field positions in the phy/switch init register
    localparam int INIT_RATE_BIT = 7;
    localparam int INIT_DUPLEX_BIT = 6;
    localparam int INIT_AUTONEG_BIT = 5;
    localparam int INIT_SOFT_RESET_BIT = 4;
    localparam int INIT_REMOTE_EN_BIT = 3;

    // field positions of the same storage seen through the port control register
    localparam int PC_RATE_BIT = 6;
    localparam int PC_DUPLEX_BIT = 5;
    localparam int PC_AUTONEG_BIT = 7;

    // reset values
    localparam logic [4:0] CMD_RESET = 5'h00;
    localparam logic REMOTE_EN_RESET = 1'b0;
    localparam logic [7:0] RD_RESET = 8'h00;
    localparam logic [23:0] MODEL_RESET = 24'h000000;

    // strap capture sequence after reset release, gray coded
    typedef enum logic [1:0] {
        STRAP_SYNC0 = 2'b00,
        STRAP_SYNC1 = 2'b01,
        STRAP_LOAD = 2'b11,
        STRAP_DONE = 2'b10
    } ocp_strap_t;
endpackage
`default_nettype wire

// file: verilog/ocp_cmd_if.sv
// carrier between the register bank and the command issuer
`timescale 1ns/1ps
`default_nettype none
interface ocp_cmd_if;
    logic cmdWrite;
    logic [4:0] cmdCode;
    logic centerSide;
    logic remoteEnable;
    logic softReset;
    logic cmdLegal;

    modport owner(output cmdWrite, output cmdCode, output centerSide, output remoteEnable,
                  output softReset, input cmdLegal);
    modport issuer(input cmdWrite, input cmdCode, input centerSide, input remoteEnable,
                   input softReset, output cmdLegal);
endinterface
`default_nettype wire

// file: verilog/ocp_cmd_issue.sv
// turns a written maintenance command code into at most one frame request pulse
`timescale 1ns/1ps
`default_nettype none
module ocp_cmd_issue
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // command from the register bank
    ocp_cmd_if.issuer cmd,
    // model info sources
    input wire logic [23:0] modelInfoLocal,
    input wire logic [23:0] modelInfoRemote,
    // frame requests to the frame engine
    output logic sendCondInform,
    output logic sendLoopStart,
    output logic sendLoopStop,
    output logic sendRemoteCmd,
    output logic sendIndicate,
    output logic [23:0] modelInfoUpperBits
);
    logic centerOk;
    logic fire;
    logic useRemote_q;

    // legality check; unlisted codes are refused and leave state alone
    // refuse unlisted codes
    always_comb
    begin
        unique case (cmd.cmdCode)
            ocp_pkg::CMD_NONE, ocp_pkg::CMD_COND_INFORM, ocp_pkg::CMD_LOOP_START,
            ocp_pkg::CMD_LOOP_STOP, ocp_pkg::CMD_REMOTE, ocp_pkg::CMD_INDICATE:
                cmd.cmdLegal = 1'b1;
            default:
                cmd.cmdLegal = 1'b0;
        endcase
    end

    assign centerOk = cmd.centerSide;
    // a soft reset in the same cycle wins, so no frame starts into a fabric being reset
    assign fire = cmd.cmdWrite & ~cmd.softReset;

    // at most one pulse per accepted command: none for CMD_NONE, and only indicate on the terminal side
    // decode request codes
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sendCondInform <= 1'b0;
            sendLoopStart <= 1'b0;
            sendLoopStop <= 1'b0;
            sendRemoteCmd <= 1'b0;
            sendIndicate <= 1'b0;
        end
        else
        begin
            sendCondInform <= fire & centerOk & (cmd.cmdCode == ocp_pkg::CMD_COND_INFORM);
            sendLoopStart <= fire & centerOk & (cmd.cmdCode == ocp_pkg::CMD_LOOP_START);
            sendLoopStop <= fire & centerOk & (cmd.cmdCode == ocp_pkg::CMD_LOOP_STOP);
            sendRemoteCmd <= fire & centerOk & cmd.remoteEnable
                             & (cmd.cmdCode == ocp_pkg::CMD_REMOTE);
            sendIndicate <= fire & (cmd.cmdCode == ocp_pkg::CMD_INDICATE);
        end
    end

    // source of the upper model info bits follows the last remote command or condition inform frame issued
    // remote model source
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            useRemote_q <= 1'b0;
        else if (fire & centerOk & cmd.remoteEnable & (cmd.cmdCode == ocp_pkg::CMD_REMOTE))
            useRemote_q <= 1'b1;
        else if (fire & centerOk & (cmd.cmdCode == ocp_pkg::CMD_COND_INFORM))
            useRemote_q <= 1'b0;
    end

    // registered so the frame engine sees a stable field for the whole frame
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            modelInfoUpperBits <= ocp_pkg::MODEL_RESET;
        else
            modelInfoUpperBits <= useRemote_q ? modelInfoRemote : modelInfoLocal;
    end
endmodule // ocp_cmd_issue
`default_nettype wire

// file: test/ocp_phy_init_regs_properties.sv
// port-level assertions for the command and port-2 init register bank
`timescale 1ns/1ps
`default_nettype none
module ocp_phy_init_regs_checker
(
    // clock, reset and register port
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic [7:0] regRdData,
    // mode and model info
    input wire logic centerSide,
    input wire logic [23:0] modelInfoLocal,
    input wire logic [23:0] modelInfoRemote,
    // configuration
    input wire logic port2RateSelect,
    input wire logic port2DuplexSelect,
    input wire logic port2AutonegEnable,
    input wire logic remoteCmdEnable,
    input wire logic fabricSoftReset,
    // frame requests
    input wire logic sendCondInform,
    input wire logic sendLoopStart,
    input wire logic sendLoopStop,
    input wire logic sendRemoteCmd,
    input wire logic sendIndicate,
    input wire logic [23:0] modelInfoUpperBits
);
    logic cmdWr;
    logic cenWr;
    logic anySend;
    logic [4:0] code;
    // a command write in the soft reset cycle is swallowed, so it never counts
    assign cmdWr = regWrite && regAddr == 8'h42 && !fabricSoftReset;
    assign cenWr = cmdWr && centerSide;
    assign code = regWrData[4:0];
    assign anySend = sendCondInform | sendLoopStart | sendLoopStop | sendRemoteCmd;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    inform_pulse_a: assert property (cenWr && code == 5'h01 |=> sendCondInform)
        else $error("inform request missing");
    loop_start_a: assert property (cenWr && code == 5'h02 |=> sendLoopStart)
        else $error("loop start missing");
    loop_stop_a: assert property (cenWr && code == 5'h04 |=> sendLoopStop)
        else $error("loop stop missing");
    remote_pulse_a: assert property (
        cenWr && remoteCmdEnable && code == 5'h08 |=> sendRemoteCmd)
        else $error("remote command missing");
    remote_gate_a: assert property (!remoteCmdEnable |=> !sendRemoteCmd)
        else $error("remote command while disabled");
    indicate_any_a: assert property (cmdWr && code == 5'h10 |=> sendIndicate)
        else $error("indicate frame missing");
    terminal_quiet_a: assert property (!centerSide |=> !anySend)
        else $error("terminal side issued a frame");
    unlisted_ignored_a: assert property (
        !(cmdWr && code inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        |=> !(anySend || sendIndicate))
        else $error("frame without a legal command");
    soft_cause_a: assert property (
        fabricSoftReset |-> $past(regWrite && regAddr == 8'h43 && regWrData[4]))
        else $error("soft reset without a write");
    // a second set write right behind the first legally stretches the pulse
    soft_pulse_a: assert property (
        regWrite && regAddr == 8'h43 && regWrData[4] |=> fabricSoftReset)
        else $error("soft reset pulse missing");
    soft_clear_a: assert property (
        fabricSoftReset && !(regWrite && regAddr == 8'h43 && regWrData[4])
        |=> !fabricSoftReset)
        else $error("soft reset did not clear");
    init_write_a: assert property (
        regWrite && regAddr == 8'h43 |=> {port2RateSelect, port2DuplexSelect,
        port2AutonegEnable, remoteCmdEnable} == $past({regWrData[7:5], regWrData[3]}))
        else $error("init write not taken");
    alias_write_a: assert property (
        regWrite && regAddr == 8'h2C |=> {port2AutonegEnable, port2RateSelect,
        port2DuplexSelect} == $past(regWrData[7:5]))
        else $error("alias write not taken");
    remote_source_a: assert property (
        sendRemoteCmd |=> modelInfoUpperBits == $past(modelInfoRemote))
        else $error("remote model info not selected");

    // main scenarios reached
    cover property (sendRemoteCmd);
    cover property (fabricSoftReset);
    cover property (sendIndicate ##1 sendIndicate);
endmodule // ocp_phy_init_regs_checker

bind ocp_phy_init_regs ocp_phy_init_regs_checker ocp_phy_init_regs_checker_inst (.*);
`default_nettype wire

// file: test/ocp_host_model.sv
// management host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module ocp_host_model
(
    // clock
    input wire logic mclk,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    input wire logic [7:0] regRdData
);
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
    end
    // host writes command
    // strobe stays up so writes may follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
    endtask
    // released data shows the inverse so a stale value never passes
    task automatic idle();
        @(negedge mclk);
        regWrite = 1'b0;
        regWrData = ~regWrData;
    endtask
    // read data follows the address by one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        idle();
        regAddr = a;
        @(negedge mclk);
        d = regRdData;
    endtask
endmodule // ocp_host_model
`default_nettype wire

// file: test/ocp_phy_init_regs_tb_top.sv
// self-checking bench for the command and port-2 init registers
`timescale 1ns/1ps
`default_nettype none
module ocp_phy_init_regs_tb_top;
    typedef struct packed {
        logic [7:0] d;
        logic c;
        logic [4:0] p;
        logic [7:0] r;
    } ocp_row_t;
    localparam logic [23:0] LOC = 24'h123456;
    localparam logic [23:0] REM = 24'hABCDEF;
    logic mclk, nrst, centerSide;
    logic strapRate, strapDup, strapAn;
    wire logic [7:0] regAddr, regWrData, regRdData;
    wire logic regWrite, rate, dup, an, remEn, softRst;
    wire logic [4:0] pulse;
    wire logic [23:0] model;
    logic [7:0] rdv;
    int n_mismatch = 0;
    int check_count = 0;
    // write data, side, expected pulses {ind,rem,stop,start,inform}, readback
    ocp_row_t rows [10] = '{
        '{8'hE1, 1'b1, 5'h01, 8'h01}, '{8'h02, 1'b1, 5'h02, 8'h02},
        '{8'h04, 1'b1, 5'h04, 8'h04}, '{8'h08, 1'b1, 5'h08, 8'h08},
        '{8'h10, 1'b1, 5'h10, 8'h10}, '{8'h10, 1'b0, 5'h10, 8'h10},
        '{8'h01, 1'b0, 5'h00, 8'h01}, '{8'h08, 1'b0, 5'h00, 8'h08},
        '{8'h03, 1'b1, 5'h00, 8'h08}, '{8'h00, 1'b1, 5'h00, 8'h00}};

    ocp_host_model host (.*);
    ocp_phy_init_regs ocp_phy_init_regs_inst (.*, .port2RateStrap(strapRate),
        .port2DuplexStrap(strapDup), .port2AutonegStrap(strapAn), .modelInfoLocal(LOC),
        .modelInfoRemote(REM), .port2RateSelect(rate), .port2DuplexSelect(dup),
        .port2AutonegEnable(an), .remoteCmdEnable(remEn), .fabricSoftReset(softRst),
        .sendCondInform(pulse[0]), .sendLoopStart(pulse[1]), .sendLoopStop(pulse[2]),
        .sendRemoteCmd(pulse[3]), .sendIndicate(pulse[4]), .modelInfoUpperBits(model));

    // compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // watchdog at 400 cycles, about four times the hundred or so cycles the run needs
    initial
    begin
        repeat (400) @(posedge mclk);
        n_mismatch++;
        final_report();
    end
    initial
    begin
        nrst = 1'b0;
        centerSide = 1'b1;
        strapRate = 1'b1;
        strapDup = 1'b0;
        strapAn = 1'b1;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        chk({rate, dup, an, remEn}, 4'hA);
        host.rd(8'h43, rdv);
        chk(rdv, 8'hA0);
        host.rd(8'h2C, rdv);
        chk(rdv, 8'hC0);
        host.wr(8'h43, 8'h48);
        host.rd(8'h2C, rdv);
        chk(rdv, 8'h20);
        host.wr(8'h2C, 8'hC0);
        host.wr(8'h99, 8'hFF);
        host.rd(8'h43, rdv);
        chk(rdv, 8'hA8);
        host.rd(8'h99, rdv);
        chk(rdv, 8'h00);
        foreach (rows[i])
        begin
            centerSide = rows[i].c;
            host.wr(8'h42, rows[i].d);
            host.idle();
            chk(pulse, rows[i].p);
            host.rd(8'h42, rdv);
            chk(rdv, rows[i].r);
            if (rows[i].p[3] || rows[i].p[0])
                chk(model, rows[i].p[3] ? REM : LOC);
        end
        // a command right behind a soft reset is swallowed
        host.wr(8'h42, 8'h02);
        host.wr(8'h43, 8'hB8);
        host.wr(8'h42, 8'h10);
        chk(softRst, 1'b1);
        host.idle();
        chk({softRst, pulse}, 6'h00);
        host.rd(8'h42, rdv);
        chk(rdv, 8'h00);
        host.rd(8'h43, rdv);
        chk(rdv, 8'hA8);
        // back-to-back indicate, then remote refused once disabled
        host.wr(8'h42, 8'h10);
        host.wr(8'h42, 8'h10);
        chk(pulse, 5'h10);
        host.wr(8'h43, 8'hA0);
        chk(pulse, 5'h10);
        host.wr(8'h42, 8'h08);
        host.idle();
        chk({remEn, pulse}, 6'h00);
        // an inform after a remote command puts the local model bits back
        host.wr(8'h42, 8'h01);
        host.idle();
        chk(pulse, 5'h01);
        host.idle();
        chk(model, LOC);
        // mid-run reset with other strap levels; the command field clears too
        @(negedge mclk);
        nrst = 1'b0;
        strapRate = 1'b0;
        strapDup = 1'b1;
        strapAn = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        chk({rate, dup, an, remEn}, 4'h4);
        host.rd(8'h43, rdv);
        chk(rdv, 8'h40);
        host.rd(8'h2C, rdv);
        chk(rdv, 8'h20);
        host.rd(8'h42, rdv);
        chk(rdv, 8'h00);
        final_report();
    end
endmodule // ocp_phy_init_regs_tb_top
`default_nettype wire
